//--- rtl/dcd_pkg.sv
// shared constants for the two-channel converter output port
package dcd_pkg;
    localparam int unsigned CHANS         = 2;
    localparam int unsigned POINTS        = 32;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned CODE_W        = 12;
    localparam int unsigned CODE_LSB      = 0;
    localparam int unsigned CNT_W         = 12;
    localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
    localparam logic [CODE_W-1:0] CODE_TOP = 12'hFFF;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CONV_TIME_NS  = 30000;
    // longest time rounds down to whole cycles
    localparam int unsigned CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] CNT_LAST =
        CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    typedef enum logic {DCD_IDLE, DCD_SETTLE} dcd_state_t;
endpackage

//--- rtl/dcd_hold_if.sv
// link between the sequencer and one channel holding stage
`timescale 1ns/100ps
`default_nettype none
interface dcd_hold_if;
    logic                            wr;
    logic [dcd_pkg::CODE_W-1:0]      wdata;
    logic                            arm;
    logic                            commit;
    logic [dcd_pkg::CODE_W-1:0]      code;
    logic                            pend;
    logic                            armed;
    modport ctl  (output wr, output wdata, output arm, output commit,
                  input code, input pend, input armed);
    modport hold (input wr, input wdata, input arm, input commit,
                  output code, output pend, output armed);
endinterface
`default_nettype wire

//--- rtl/dcd_hold.sv
// one channel: staged code, armed copy and converter code
`timescale 1ns/100ps
`default_nettype none
module dcd_hold (
    input  wire logic clock_i,
    input  wire logic rst_i,
    dcd_hold_if.hold  hb
);
    logic [dcd_pkg::CODE_W-1:0] staged_ff;
    logic [dcd_pkg::CODE_W-1:0] nxt_staged;
    logic [dcd_pkg::CODE_W-1:0] latch_ff;
    logic [dcd_pkg::CODE_W-1:0] nxt_latch;
    logic [dcd_pkg::CODE_W-1:0] code_ff;
    logic [dcd_pkg::CODE_W-1:0] nxt_code;
    logic                       pend_ff;
    logic                       nxt_pend;
    logic                       armed_ff;
    logic                       nxt_armed;

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    always_comb begin
        nxt_staged = staged_ff;
        nxt_latch  = latch_ff;
        nxt_code   = code_ff;
        nxt_pend   = pend_ff;
        nxt_armed  = armed_ff;
        if (hb.wr) begin
            nxt_staged = hb.wdata;
        end
        if (hb.arm) begin
            nxt_latch = staged_ff;
            nxt_armed = pend_ff;
            nxt_pend  = 1'b0;
        end
        // a write in the arming cycle stays pending for the next scan
        if (hb.wr) begin
            nxt_pend = 1'b1;
        end
        if (hb.commit) begin
            nxt_armed = 1'b0;
            if (armed_ff) begin
                nxt_code = latch_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            staged_ff <= dcd_pkg::CODE_RST;
            latch_ff  <= dcd_pkg::CODE_RST;
            code_ff   <= dcd_pkg::CODE_RST;
            pend_ff   <= 1'b0;
            armed_ff  <= 1'b0;
        end else begin
            staged_ff <= nxt_staged;
            latch_ff  <= nxt_latch;
            code_ff   <= nxt_code;
            pend_ff   <= nxt_pend;
            armed_ff  <= nxt_armed;
        end
    end

    assign hb.code  = code_ff;
    assign hb.pend  = pend_ff;
    assign hb.armed = armed_ff;
endmodule
`default_nettype wire

//--- rtl/dcd_top.sv
// two-channel converter output port: host words in, codes out
`timescale 1ns/100ps
`default_nettype none
module dcd_top (
    input  wire logic                                       clock_i,
    input  wire logic                                       rst_i,
    input  wire logic                                       scan_start_i,
    input  wire logic [dcd_pkg::CHANS-1:0]                  word_wr_i,
    input  wire logic [dcd_pkg::POINTS-1:0]                 points_i,
    output logic [dcd_pkg::CHANS-1:0][dcd_pkg::CODE_W-1:0]  dac_code_o,
    output logic [dcd_pkg::CHANS-1:0]                       dac_load_o,
    output logic                                            busy_o
);
    dcd_pkg::dcd_state_t             state_ff;
    dcd_pkg::dcd_state_t             nxt_state;
    logic [dcd_pkg::CNT_W-1:0]       cnt_ff;
    logic [dcd_pkg::CNT_W-1:0]       nxt_cnt;
    logic [dcd_pkg::CHANS-1:0]       load_ff;
    logic [dcd_pkg::CHANS-1:0]       nxt_load;
    logic                            busy_ff;
    logic                            nxt_busy;
    logic                            arm;
    logic                            commit;
    logic [dcd_pkg::CHANS-1:0]       pend;
    logic [dcd_pkg::CHANS-1:0]       armed;

    dcd_hold_if hif [dcd_pkg::CHANS] ();

    // ----------------------------------------------------------------
    // per-channel holding stages
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < dcd_pkg::CHANS; ch++) begin : g_ch
        // upper nibble of each word is never wired in
        assign hif[ch].wr     = word_wr_i[ch];
        assign hif[ch].wdata  =
            points_i[ch*dcd_pkg::WORD_W + dcd_pkg::CODE_LSB
                     +: dcd_pkg::CODE_W];
        assign hif[ch].arm    = arm;
        assign hif[ch].commit = commit;
        assign pend[ch]       = hif[ch].pend;
        assign armed[ch]      = hif[ch].armed;
        assign dac_code_o[ch] = hif[ch].code;
        dcd_hold u_hold (
            .clock_i (clock_i),
            .rst_i   (rst_i),
            .hb      (hif[ch])
        );
    end

    // ----------------------------------------------------------------
    // scan sequencer
    // ----------------------------------------------------------------
    // only idle accepts a scan start: a scan inside the settle window
    // leaves writes pending for the following scan
    assign arm    = (state_ff == dcd_pkg::DCD_IDLE) && scan_start_i
                    && (|pend);
    assign commit = (state_ff == dcd_pkg::DCD_SETTLE)
                    && (cnt_ff == dcd_pkg::CNT_ZERO);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_load  = '0;
        nxt_busy  = busy_ff;
        case (state_ff)
            dcd_pkg::DCD_IDLE: begin
                if (arm) begin
                    nxt_state = dcd_pkg::DCD_SETTLE;
                    nxt_cnt   = dcd_pkg::CNT_LAST;
                    nxt_busy  = 1'b1;
                end
            end
            dcd_pkg::DCD_SETTLE: begin
                if (commit) begin
                    nxt_state = dcd_pkg::DCD_IDLE;
                    nxt_load  = armed;
                    nxt_busy  = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = dcd_pkg::DCD_IDLE;
                nxt_cnt   = dcd_pkg::CNT_ZERO;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_ff <= dcd_pkg::DCD_IDLE;
            cnt_ff   <= dcd_pkg::CNT_ZERO;
            load_ff  <= '0;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            load_ff  <= nxt_load;
            busy_ff  <= nxt_busy;
        end
    end

    assign dac_load_o = load_ff;
    assign busy_o     = busy_ff;
endmodule
`default_nettype wire

//--- verif/dcd_assertions.sv
// concurrent checks on the converter output port
`timescale 1ns/100ps
`default_nettype none
module dcd_assertions (
    input wire logic             clock_i,
    input wire logic             rst_i,
    input wire logic             scan_start_i,
    input wire logic [1:0][11:0] dac_code_o,
    input wire logic [1:0]       dac_load_o,
    input wire logic             busy_o
);
    logic [12:0] cnt_ff;
    logic [12:0] nxt_cnt;
    always_comb nxt_cnt = busy_o ? cnt_ff + 13'h1 : 13'h0;
    always_ff @(posedge clock_i) cnt_ff <= rst_i ? 13'h0 : nxt_cnt;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_accept; !busy_o ##1 busy_o; endsequence
    sequence s_commit; $fell(busy_o) ##0 (|dac_load_o); endsequence
    a_accept_cause:
        assert property (s_accept |-> $past(scan_start_i)) else $error("busy");
    a_settle_len:
        assert property ($fell(busy_o) |-> cnt_ff == 13'(dcd_pkg::CONV_CYC))
        else $error("settle length");
    a_settle_cap:
        assert property (busy_o |-> cnt_ff < 13'(dcd_pkg::CONV_CYC))
        else $error("settle long");
    a_load_at_end:
        assert property (|dac_load_o |-> $fell(busy_o)) else $error("load");
    a_load_pulse:
        assert property (s_commit |=> dac_load_o == 2'b00)
        else $error("pulse");
    a_code0_load:
        assert property (!$stable(dac_code_o[0]) |-> dac_load_o[0])
        else $error("ch0 moved");
    a_code1_load:
        assert property (!$stable(dac_code_o[1]) |-> dac_load_o[1])
        else $error("ch1 moved");
    a_quiet_busy:
        assert property (busy_o |-> $stable(dac_code_o)) else $error("mixed");
endmodule
`default_nettype wire

//--- verif/dcd_host_model.sv
// host side: writes channel words and marks scan starts
`timescale 1ns/100ps
`default_nettype none
module dcd_host_model (
    input  wire logic   clock_i,
    output logic        scan_o,
    output logic [1:0]  wr_o,
    output logic [31:0] pts_o
);
    initial begin
        scan_o = 1'b0;
        wr_o = 2'b00;
        pts_o = 32'h0;
    end
    // whole words on 16-bit boundaries, one or both per scan
    task automatic put(input logic [1:0]  m,
                       input logic [31:0] w);
        @(posedge clock_i);
        #1 wr_o = m;
        pts_o = w;
        @(posedge clock_i);
        #1 wr_o = 2'b00;
        // released points must not keep the word
        pts_o = ~w;
    endtask
    task automatic scan();
        @(posedge clock_i);
        #1 scan_o = 1'b1;
        @(posedge clock_i);
        #1 scan_o = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the converter output port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic             clock_i     = 1'b0;
    logic             rst_i       = 1'b1;
    logic             scan;
    logic             busy;
    logic [1:0]       wr;
    logic [1:0]       load;
    logic [31:0]      pts;
    logic [1:0][11:0] code;
    logic [11:0]      staged [2];
    logic [11:0]      exq [2][$];
    logic [1:0]       pend        = 2'b00;
    int               bad_count   = 0;
    int               checks_done = 0;
    int               seed        = 89842;
    always #4 clock_i = ~clock_i;
    dcd_host_model p (.clock_i(clock_i), .scan_o(scan), .wr_o(wr),
        .pts_o(pts));
    dcd_top i_dut (.clock_i(clock_i), .rst_i(rst_i), .scan_start_i(scan),
        .word_wr_i(wr), .points_i(pts), .dac_code_o(code),
        .dac_load_o(load), .busy_o(busy));
    task automatic chk(string n, logic [11:0] s, logic [11:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wrc(logic [1:0] m, logic [31:0] w);
        for (int c = 0; c < 2; c++) if (m[c]) staged[c] = w[c*16 +: 12];
        pend |= m;
        p.put(m, w);
    endtask
    task automatic arm();
        for (int c = 0; c < 2; c++) if (pend[c]) exq[c].push_back(staged[c]);
        pend = 2'b00;
        p.scan();
    endtask
    task automatic done(int t);
        for (int i = 0; i < 4000 && exq[0].size() + exq[1].size() > 0; i++)
            @(posedge clock_i);
        if (exq[0].size() + exq[1].size() > 0) begin
            bad_count++;
            close_out();
        end else begin
            $display("test %0d done", t);
        end
    endtask
    always @(negedge clock_i)
        for (int c = 0; c < 2; c++) if (load[c] === 1'b1) begin
            if (exq[c].size() == 0) chk("stray load", 12'h0, 12'h1);
            else chk("code", code[c], exq[c].pop_front());
        end
    initial begin
        repeat (6) @(posedge clock_i);
        #1 rst_i = 1'b0;
        wrc(2'b10, 32'hF5A5_0000);
        arm();
        done(1);
        wrc(2'b11, 32'hF000_0FFF);
        arm();
        done(2);
        wrc(2'b01, 32'h0000_0123);
        wrc(2'b01, 32'h0000_0456);
        arm();
        // scan while settling is dropped, the write waits
        wrc(2'b01, 32'h0000_0789);
        p.scan();
        done(3);
        arm();
        done(4);
        p.scan();
        repeat (2) @(posedge clock_i);
        // look after the edge has settled, not in its own time step
        #1 chk("idle busy", {11'h0, busy}, 12'h0);
        $display("test idle scan done");
        for (int t = 5; t < 9; t++) begin
            wrc(2'(1 + $unsigned($random(seed)) % 3), $random(seed));
            arm();
            done(t);
        end
        close_out();
    end
endmodule
bind dcd_top dcd_assertions u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .scan_start_i(scan_start_i), .dac_code_o(dac_code_o),
    .dac_load_o(dac_load_o), .busy_o(busy_o));
`default_nettype wire
